//--- verif/fw_dl_props.sv
`timescale 1ns/1ps
`default_nettype none
module fw_dl_props
    import fw_dl_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // Command and data handshakes
    input  wire logic        cmd_valid,
    input  wire logic        cmd_ready,
    input  wire logic [4:0]  cmd_mode,
    input  wire logic [7:0]  cmd_buf_id,
    input  wire logic [23:0] cmd_offset,
    input  wire logic [23:0] cmd_len,
    input  wire logic        dat_valid,
    input  wire logic        dat_ready,
    // Response
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_status,
    input  wire logic [3:0]  rsp_key,
    input  wire logic [7:0]  rsp_asc
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    wire logic take  = cmd_valid && cmd_ready;
    wire logic temp  = take && cmd_mode == MODE_TEMP;
    wire logic rej   = rsp_valid && rsp_status == STATUS_CHECK && rsp_key == SENSE_ILLEGAL
                       && rsp_asc == ASC_INV_FIELD;
    wire logic known = cmd_mode inside {MODE_TEMP, MODE_SAVE, MODE_SEGMENT, MODE_ECHO,
                                        MODE_DEFER, MODE_ACTIVATE, MODE_EXPANDER};

    property p_temp_id;
        temp && cmd_buf_id != BUF_ID_MAIN |-> ##3 rej;
    endproperty
    a_temp_id: assert property (p_temp_id) else $error("temp id not refused");

    // A temp command refused for its offset must never open a data phase
    property p_temp_off;
        temp && cmd_offset != OFFSET_ZERO |=> (!dat_ready && !rsp_valid) [*2] ##1 rej;
    endproperty
    a_temp_off: assert property (p_temp_off) else $error("temp offset not refused");

    property p_temp_len;
        temp && cmd_len != LEN_ZERO && cmd_len != DATA_SET_SIZE |-> ##3 rej;
    endproperty
    a_temp_len: assert property (p_temp_len) else $error("temp length not refused");

    property p_temp_zero;
        temp && cmd_len == LEN_ZERO && cmd_buf_id == BUF_ID_MAIN && cmd_offset == OFFSET_ZERO
        |=> !dat_ready [*2] ##1 (rsp_valid && rsp_status == STATUS_GOOD);
    endproperty
    a_temp_zero: assert property (p_temp_zero) else $error("zero length not plain good");

    property p_seg_len;
        take && cmd_mode == MODE_SEGMENT && cmd_len[11:0] != 12'h000 |-> ##3 rej;
    endproperty
    a_seg_len: assert property (p_seg_len) else $error("segment length not refused");

    property p_echo_len;
        take && cmd_mode == MODE_ECHO && cmd_len[1:0] != 2'h0 |-> ##3 rej;
    endproperty
    a_echo_len: assert property (p_echo_len) else $error("echo length not refused");

    property p_exp_len;
        take && cmd_mode == MODE_EXPANDER && cmd_len[1:0] != 2'h0 |-> ##3 rej;
    endproperty
    a_exp_len: assert property (p_exp_len) else $error("expander length not refused");

    property p_activate;
        take && cmd_mode == MODE_ACTIVATE
        |=> !dat_ready [*2] ##1 (rsp_valid && rsp_status == STATUS_GOOD);
    endproperty
    a_activate: assert property (p_activate) else $error("activate not plain good");

    property p_bad_mode;
        take && !known |-> ##3 rej;
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("unknown mode not refused");

    c_word: cover property (dat_valid && dat_ready);
    c_good: cover property (rsp_valid && rsp_status == STATUS_GOOD);
    c_rej:  cover property (take && !known ##3 rej);
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fw_dl_pkg::*;
    logic              ref_clk_i = 1'b0;
    logic              rst_b_i   = 1'b0;
    logic              start_i   = 1'b0;
    logic [4:0]        mode_i    = 5'h00;
    logic [7:0]        buf_id_i  = 8'h00;
    logic [23:0]       offset_i  = 24'h00_0000;
    logic [23:0]       len_i     = 24'h00_0000;
    logic [INIT_W-1:0] init_i    = 2'h1;
    logic              wr_valid_i = 1'b0;
    logic [31:0]       wr_word_i = 32'h0000_0000;
    logic              power_on_i = 1'b0;
    logic              self_reset_i = 1'b0;
    logic [23:0]       file_len_i = 24'h00_2000;
    logic [ECHO_AW-1:0] echo_rd_addr_i = 6'h00;
    logic              busy_o, wr_ready_o, done_o, timeout_o, code_write_o, run_temp_o;
    logic              save_commit_o, self_reset_req_o, deferred_pending_o, activate_o;
    logic [7:0]        status_o, asc_o;
    logic [3:0]        key_o;
    logic [NUM_INIT-1:0] unit_attn_o, ua;
    logic [23:0]       seg_bytes_o;
    logic [31:0]       echo_rd_data_o, base, cw, code_word_o;
    logic [19:0]       rsp;
    logic              sc, sr, act;
    int                n_fail = 0;
    int                checks = 0;
    int                cyc = 0;

    fw_dl_if link ();
    fw_dl_device i_fw_dl_device (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .link(link),
        .power_on_i(power_on_i), .self_reset_i(self_reset_i), .file_len_i(file_len_i),
        .code_write_o(code_write_o), .code_word_o(code_word_o), .run_temp_o(run_temp_o),
        .save_commit_o(save_commit_o), .self_reset_req_o(self_reset_req_o),
        .deferred_pending_o(deferred_pending_o), .activate_o(activate_o),
        .unit_attn_o(unit_attn_o), .seg_bytes_o(seg_bytes_o),
        .echo_rd_data_o(echo_rd_data_o), .echo_rd_addr_i(echo_rd_addr_i));
    // Short host guard keeps a hang visible within the run
    fw_dl_host #(.TIMEOUT_CYC(20000)) i_fw_dl_host (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .link(link), .start_i(start_i), .mode_i(mode_i), .buf_id_i(buf_id_i),
        .offset_i(offset_i), .len_i(len_i), .init_i(init_i), .busy_o(busy_o),
        .wr_valid_i(wr_valid_i), .wr_word_i(wr_word_i), .wr_ready_o(wr_ready_o),
        .done_o(done_o), .timeout_o(timeout_o), .status_o(status_o), .key_o(key_o),
        .asc_o(asc_o));
    fw_dl_props i_fw_dl_props (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
        .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_mode(link.cmd_mode),
        .cmd_buf_id(link.cmd_buf_id), .cmd_offset(link.cmd_offset), .cmd_len(link.cmd_len),
        .dat_valid(link.dat_valid), .dat_ready(link.dat_ready), .rsp_valid(link.rsp_valid),
        .rsp_status(link.rsp_status), .rsp_key(link.rsp_key), .rsp_asc(link.rsp_asc));

    always #2.5 ref_clk_i = ~ref_clk_i;

    // Pulses are gathered at the falling edge, away from the tasks' updates
    always @(negedge ref_clk_i)
    begin
        ua  = ua | unit_attn_o;
        sc  = sc | save_commit_o;
        sr  = sr | self_reset_req_o;
        act = act | activate_o;
        cw  = cw + {31'd0, code_write_o};
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic good(input logic ok);
        chk({30'h0000_0000, busy_o, timeout_o}, 32'h0000_0000);
        if (ok)
            chk({12'h000, rsp}, {12'h000, STATUS_GOOD, SENSE_NONE, ASC_NONE});
        else
            chk({12'h000, rsp}, {12'h000, STATUS_CHECK, SENSE_ILLEGAL, ASC_INV_FIELD});
    endtask

    task automatic cmd(input logic [4:0] m, input logic [7:0] id, input logic [23:0] off,
                       input logic [23:0] len, input int nw);
        int  n;
        int  k;
        logic dn;
        n = 0;
        k = 0;
        dn = 1'b0;
        @(posedge ref_clk_i);
        {ua, sc, sr, act, cw} = '0;
        mode_i <= m;
        buf_id_i <= id;
        offset_i <= off;
        len_i <= len;
        start_i <= 1'b1;
        wr_valid_i <= (nw > 0);
        wr_word_i <= base;
        @(posedge ref_clk_i);
        start_i <= 1'b0;
        while (!dn && k < 20000)
        begin
            @(posedge ref_clk_i);
            k++;
            if (wr_valid_i === 1'b1 && wr_ready_o === 1'b1)
            begin
                n++;
                wr_word_i <= base + n;
                if (n == nw)
                    wr_valid_i <= 1'b0;
            end
            if (done_o === 1'b1)
                dn = 1'b1;
        end
        if (!dn)
            n_fail++;
        repeat (2) @(posedge ref_clk_i);
        rsp = {status_o, key_o, asc_o};
    endtask

    task automatic t_temp();
        cmd(MODE_TEMP, 8'h00, 24'h00_0000, DATA_SET_SIZE, 16384);
        good(1'b1);
        chk(cw, {8'h00, DATA_SET_SIZE} >> 2);
        chk(code_word_o, base + ({8'h00, DATA_SET_SIZE} >> 2) - 32'h0000_0001);
        chk(run_temp_o, 1);
        chk(ua, 4'b1101);
        cmd(MODE_TEMP, 8'h01, 24'h00_0000, DATA_SET_SIZE, 0);
        good(1'b0);
        cmd(MODE_TEMP, 8'h00, 24'h00_0004, DATA_SET_SIZE, 0);
        good(1'b0);
        cmd(MODE_TEMP, 8'h00, 24'h00_0000, 24'h00_0008, 0);
        good(1'b0);
        cmd(MODE_TEMP, 8'h00, 24'h00_0000, 24'h00_0000, 0);
        good(1'b1);
        chk({ua, cw[27:0]}, 32'h0000_0000);
        @(posedge ref_clk_i);
        power_on_i <= 1'b1;
        @(posedge ref_clk_i);
        power_on_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk(run_temp_o, 0);
        $display("test temp done");
    endtask

    task automatic t_save();
        cmd(MODE_SAVE, 8'h00, 24'h00_0000, 24'h00_0010, 4);
        good(1'b1);
        chk({sc, sr, ua}, 6'b11_1101);
        cmd(MODE_SEGMENT, 8'h00, 24'h00_0000, 24'h00_1000, 1024);
        good(1'b1);
        chk({sc, seg_bytes_o}, 25'h000_1000);
        cmd(MODE_SEGMENT, 8'h00, 24'h00_0000, 24'h00_0800, 0);
        good(1'b0);
        chk(seg_bytes_o, 0);
        cmd(MODE_SEGMENT, 8'h00, 24'h12_3456, 24'h00_1000, 1024);
        good(1'b1);
        cmd(MODE_SEGMENT, 8'h33, 24'h00_0000, 24'h00_1000, 1024);
        good(1'b1);
        chk({sc, sr}, 2'b11);
        $display("test save done");
    endtask

    task automatic echo_chk(input int nw);
        for (int i = 0; i < nw; i++)
        begin
            @(posedge ref_clk_i);
            echo_rd_addr_i <= i[ECHO_AW-1:0];
            repeat (2) @(posedge ref_clk_i);
            chk(echo_rd_data_o, base + i);
        end
    endtask

    task automatic t_echo();
        base = 32'hA5A5_0000;
        cmd(MODE_ECHO, 8'h00, 24'h00_0000, 24'h00_0010, 4);
        good(1'b1);
        cmd(MODE_ECHO, 8'h00, 24'h00_0000, 24'h00_0006, 0);
        good(1'b0);
        echo_chk(4);
        base = 32'h5A5A_0100;
        cmd(MODE_EXPANDER, 8'h00, 24'h00_0000, 24'h00_0008, 2);
        good(1'b1);
        echo_chk(2);
        $display("test echo done");
    endtask

    task automatic t_defer();
        for (int i = 0; i < 3; i++)
        begin
            cmd(MODE_DEFER, 8'h00, 24'h00_0000, 24'h00_0010, 4);
            good(1'b1);
            chk({deferred_pending_o, ua}, 5'h10);
            @(posedge ref_clk_i);
            if (i == 0)
                cmd(MODE_ACTIVATE, 8'h05, 24'h00_0007, 24'h00_0123, 0);
            self_reset_i <= (i == 1);
            power_on_i <= (i == 2);
            @(posedge ref_clk_i);
            {self_reset_i, power_on_i} <= 2'b00;
            repeat (2) @(posedge ref_clk_i);
            chk(deferred_pending_o, 0);
            chk(act, 1'b1);
        end
        $display("test defer done");
    endtask

    task automatic t_modes();
        logic [4:0] bad [4];
        bad = '{5'h01, 5'h03, 5'h08, 5'h1F};
        foreach (bad[i])
        begin
            cmd(bad[i], 8'h00, 24'h00_0000, 24'h00_0010, 0);
            good(1'b0);
        end
        $display("test modes done");
    endtask

    initial
    begin
        base = 32'h0000_1000;
        repeat (4) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        t_temp();
        t_save();
        t_echo();
        t_defer();
        t_modes();
        stop_test();
    end
endmodule
`default_nettype wire

//--- verilog/fw_dl_device.sv
`timescale 1ns/1ps
`default_nettype none
module fw_dl_device
    import fw_dl_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // Link to initiator
    fw_dl_if.dev                   link,
    // Drive events
    input  wire logic              power_on_i,
    input  wire logic              self_reset_i,
    input  wire logic [23:0]       file_len_i,
    output logic                   code_write_o,
    output logic [31:0]            code_word_o,
    output logic                   run_temp_o,
    output logic                   save_commit_o,
    output logic                   self_reset_req_o,
    output logic                   deferred_pending_o,
    output logic                   activate_o,
    output logic [NUM_INIT-1:0]    unit_attn_o,
    output logic [23:0]            seg_bytes_o,
    output logic [31:0]            echo_rd_data_o,
    input  wire logic [ECHO_AW-1:0] echo_rd_addr_i
);

    dev_state_t        state;
    logic [4:0]        mode;
    logic [23:0]       len;
    logic [23:0]       left;
    logic [INIT_W-1:0] init;
    logic              bad;
    logic              seg_restart;
    logic              after_check;
    logic [ECHO_AW-1:0] echo_ptr;
    logic [31:0]       echo_mem [ECHO_DEPTH];
    logic              code_ok;

    function automatic logic is_echo(input logic [4:0] m);
        is_echo = (m == MODE_ECHO) || (m == MODE_EXPANDER);
    endfunction

    function automatic logic is_code(input logic [4:0] m);
        is_code = (m == MODE_TEMP) || (m == MODE_SAVE) || (m == MODE_SEGMENT)
                  || (m == MODE_DEFER);
    endfunction

    // Field checks for a freshly accepted command
    function automatic logic field_bad(input logic [4:0] m, input logic [7:0] id,
                                       input logic [23:0] off, input logic [23:0] l);
        unique case (m)
            MODE_TEMP:     field_bad = (id != BUF_ID_MAIN)
                                       || (off != OFFSET_ZERO)
                                       || (l != LEN_ZERO && l != DATA_SET_SIZE);
            MODE_SAVE:     field_bad = 1'b0;
            MODE_SEGMENT:  field_bad = (l[SEG_ALIGN_BITS-1:0] & SEG_ALIGN_MASK) != 12'h000;
            MODE_ECHO,
            MODE_EXPANDER: field_bad = (l[1:0] & WORD_ALIGN_MASK) != 2'h0;
            MODE_DEFER:    field_bad = 1'b0;
            MODE_ACTIVATE: field_bad = 1'b0;
            default:       field_bad = 1'b1;
        endcase
    endfunction

    assign link.cmd_ready = (state == ST_IDLE);
    assign link.dat_ready = (state == ST_DATA);
    // High when this segment brings the running count up to the whole file
    assign code_ok        = (seg_bytes_o + len == file_len_i);

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state <= ST_IDLE;
            mode  <= MODE_ECHO;
            len   <= LEN_ZERO;
            left  <= LEN_ZERO;
            init  <= '0;
            bad   <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_IDLE:
                    if (link.cmd_valid)
                    begin
                        mode  <= link.cmd_mode;
                        len   <= link.cmd_len;
                        left  <= link.cmd_len;
                        init  <= link.cmd_init;
                        bad   <= field_bad(link.cmd_mode, link.cmd_buf_id,
                                           link.cmd_offset, link.cmd_len);
                        state <= ST_CHECK;
                    end
                ST_CHECK:
                    if (bad || mode == MODE_ACTIVATE || left == LEN_ZERO)
                        state <= ST_DONE;
                    else
                        state <= ST_DATA;
                ST_DATA:
                    if (link.dat_valid)
                    begin
                        if (left <= WORD_BYTES)
                        begin
                            left  <= LEN_ZERO;
                            state <= ST_DONE;
                        end
                        else
                            left <= left - WORD_BYTES;
                    end
                ST_DONE:
                    state <= ST_RESP;
                ST_RESP:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Response, a one-cycle pulse
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            link.rsp_valid  <= 1'b0;
            link.rsp_status <= STATUS_GOOD;
            link.rsp_key    <= SENSE_NONE;
            link.rsp_asc    <= ASC_NONE;
        end
        else
        begin
            link.rsp_valid  <= (state == ST_DONE);
            if (state == ST_DONE)
            begin
                link.rsp_status <= bad ? STATUS_CHECK : STATUS_GOOD;
                link.rsp_key    <= bad ? SENSE_ILLEGAL : SENSE_NONE;
                link.rsp_asc    <= bad ? ASC_INV_FIELD : ASC_NONE;
            end
        end
    end

    // Code stream out to control memory or flash
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            code_write_o <= 1'b0;
            code_word_o  <= 32'h0000_0000;
        end
        else
        begin
            code_write_o <= (state == ST_DATA) && link.dat_valid && is_code(mode);
            if ((state == ST_DATA) && link.dat_valid)
                code_word_o <= link.dat_word;
        end
    end

    // Echo buffer; only echo and expander commands write it, so contents hold otherwise
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
            echo_ptr <= '0;
        else if (state == ST_CHECK)
            echo_ptr <= '0;
        else if ((state == ST_DATA) && link.dat_valid && is_echo(mode))
            echo_ptr <= echo_ptr + 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if ((state == ST_DATA) && link.dat_valid && is_echo(mode))
            echo_mem[echo_ptr] <= link.dat_word;
        echo_rd_data_o <= echo_mem[echo_rd_addr_i];
    end

    // Segmented and deferred byte count and restart tracking
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            seg_bytes_o <= LEN_ZERO;
            after_check <= 1'b0;
        end
        else if (state == ST_DONE)
        begin
            if (bad)
            begin
                seg_bytes_o <= LEN_ZERO;
                after_check <= (mode == MODE_SEGMENT);
            end
            else if (mode == MODE_SEGMENT)
            begin
                seg_bytes_o <= code_ok ? LEN_ZERO : seg_bytes_o + len;
                after_check <= 1'b0;
            end
            else if (mode == MODE_DEFER)
                seg_bytes_o <= LEN_ZERO;
        end
        else if (state == ST_CHECK && seg_restart)
            seg_bytes_o <= LEN_ZERO;
    end

    assign seg_restart = (mode == MODE_SEGMENT) && after_check;

    // Completion effects
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            run_temp_o       <= 1'b0;
            save_commit_o    <= 1'b0;
            self_reset_req_o <= 1'b0;
            unit_attn_o      <= '0;
        end
        else
        begin
            save_commit_o    <= 1'b0;
            self_reset_req_o <= 1'b0;
            unit_attn_o      <= '0;
            if (power_on_i)
                run_temp_o <= 1'b0;
            if (state == ST_DONE && !bad && len != LEN_ZERO)
            begin
                if (mode == MODE_TEMP)
                    run_temp_o <= 1'b1;
                if (mode == MODE_SAVE
                    || (mode == MODE_SEGMENT && code_ok))
                begin
                    save_commit_o    <= 1'b1;
                    self_reset_req_o <= 1'b1;
                end
                if (is_code(mode) && mode != MODE_DEFER)
                    unit_attn_o <= ~(NUM_INIT'(1) << init);
            end
        end
    end

    // Deferred code pending and activation
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            deferred_pending_o <= 1'b0;
            activate_o         <= 1'b0;
        end
        else
        begin
            activate_o <= 1'b0;
            if (state == ST_DONE && !bad && mode == MODE_DEFER && len != LEN_ZERO)
                deferred_pending_o <= 1'b1;
            else if (deferred_pending_o && (power_on_i || self_reset_i
                     || (state == ST_DONE && mode == MODE_ACTIVATE)))
            begin
                deferred_pending_o <= 1'b0;
                activate_o         <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

//--- verilog/fw_dl_host.sv
`timescale 1ns/1ps
`default_nettype none
module fw_dl_host
    import fw_dl_pkg::*;
#(
    parameter longint TIMEOUT_CYC = SAVE_TIMEOUT_CYC
)
(
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_b_i,
    // Link to device
    fw_dl_if.host                  link,
    // User command
    input  wire logic              start_i,
    input  wire logic [4:0]        mode_i,
    input  wire logic [7:0]        buf_id_i,
    input  wire logic [23:0]       offset_i,
    input  wire logic [23:0]       len_i,
    input  wire logic [INIT_W-1:0] init_i,
    output logic                   busy_o,
    // User data
    input  wire logic              wr_valid_i,
    input  wire logic [31:0]       wr_word_i,
    output logic                   wr_ready_o,
    // Result
    output logic                   done_o,
    output logic                   timeout_o,
    output logic [7:0]             status_o,
    output logic [3:0]             key_o,
    output logic [7:0]             asc_o
);

    host_state_t  state;
    logic [63:0]  wait_cnt;

    assign busy_o          = (state != HS_IDLE);
    assign link.cmd_valid  = (state == HS_CMD);
    assign link.dat_valid  = (state == HS_DATA) && wr_valid_i;
    assign link.dat_word   = wr_word_i;
    assign wr_ready_o      = (state == HS_DATA) && link.dat_ready;

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            state           <= HS_IDLE;
            link.cmd_mode   <= MODE_ECHO;
            link.cmd_buf_id <= BUF_ID_MAIN;
            link.cmd_offset <= OFFSET_ZERO;
            link.cmd_len    <= LEN_ZERO;
            link.cmd_init   <= '0;
        end
        else
        begin
            unique case (state)
                HS_IDLE:
                    if (start_i)
                    begin
                        link.cmd_mode <= mode_i;
                        // MODE_SAVE downloads always name the main code image; segmented saves keep buf_id_i
                        link.cmd_buf_id <= (mode_i == MODE_SAVE) ? BUF_ID_MAIN
                                                                 : buf_id_i;
                        link.cmd_offset <= offset_i;
                        link.cmd_len    <= len_i;
                        link.cmd_init   <= init_i;
                        state           <= HS_CMD;
                    end
                HS_CMD:
                    if (link.cmd_ready)
                        state <= HS_DATA;
                HS_DATA:
                    if (link.rsp_valid || timeout_o)
                        state <= HS_WAIT;
                HS_WAIT:
                    state <= HS_IDLE;
            endcase
        end
    end

    // Guard time for saved updates
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i || state != HS_DATA)
            wait_cnt <= 64'h0000_0000_0000_0000;
        else
            wait_cnt <= wait_cnt + 64'h0000_0000_0000_0001;
    end
    assign timeout_o = (wait_cnt >= 64'(TIMEOUT_CYC));

    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_b_i)
        begin
            done_o   <= 1'b0;
            status_o <= STATUS_GOOD;
            key_o    <= SENSE_NONE;
            asc_o    <= ASC_NONE;
        end
        else
        begin
            done_o <= (state == HS_DATA) && link.rsp_valid;
            if ((state == HS_DATA) && link.rsp_valid)
            begin
                status_o <= link.rsp_status;
                key_o    <= link.rsp_key;
                asc_o    <= link.rsp_asc;
            end
        end
    end

    // Segment order and total length are kept by the user feeding start_i

endmodule
`default_nettype wire

//--- verilog/fw_dl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fw_dl_if;
    import fw_dl_pkg::*;
    logic              cmd_valid;
    logic              cmd_ready;
    logic [4:0]        cmd_mode;
    logic [7:0]        cmd_buf_id;
    logic [23:0]       cmd_offset;
    logic [23:0]       cmd_len;
    logic [INIT_W-1:0] cmd_init;
    logic              dat_valid;
    logic              dat_ready;
    logic [31:0]       dat_word;
    logic              rsp_valid;
    logic [7:0]        rsp_status;
    logic [3:0]        rsp_key;
    logic [7:0]        rsp_asc;

    modport dev
    (
        input  cmd_valid, cmd_mode, cmd_buf_id, cmd_offset, cmd_len, cmd_init,
        input  dat_valid, dat_word,
        output cmd_ready, dat_ready, rsp_valid, rsp_status, rsp_key, rsp_asc
    );
    modport host
    (
        output cmd_valid, cmd_mode, cmd_buf_id, cmd_offset, cmd_len, cmd_init,
        output dat_valid, dat_word,
        input  cmd_ready, dat_ready, rsp_valid, rsp_status, rsp_key, rsp_asc
    );
endinterface
`default_nettype wire

//--- verilog/fw_dl_pkg.sv
package fw_dl_pkg;

    // Mode field values (5 bits)
    localparam logic [4:0] MODE_TEMP      = 5'h04;
    localparam logic [4:0] MODE_SAVE      = 5'h05;
    localparam logic [4:0] MODE_SEGMENT   = 5'h07;
    localparam logic [4:0] MODE_ECHO      = 5'h0A;
    localparam logic [4:0] MODE_DEFER     = 5'h0E;
    localparam logic [4:0] MODE_ACTIVATE  = 5'h0F;
    localparam logic [4:0] MODE_EXPANDER  = 5'h1A;

    localparam logic [7:0] BUF_ID_MAIN    = 8'h00;
    localparam logic [23:0] OFFSET_ZERO   = 24'h00_0000;
    localparam logic [23:0] LEN_ZERO      = 24'h00_0000;
    // Bytes carried by one data word
    localparam logic [23:0] WORD_BYTES    = 24'h00_0004;
    // Segment lengths must be a multiple of 4 KiB: low 12 bits zero
    localparam int          SEG_ALIGN_BITS = 12;
    localparam logic [11:0] SEG_ALIGN_MASK = 12'hFFF;
    // Echo data arrives in 4-byte words: low 2 bits zero
    localparam logic [1:0]  WORD_ALIGN_MASK = 2'h3;

    // Default data set size for the temporary download (arbitrary)
    localparam logic [23:0] DATA_SET_SIZE = 24'h01_0000;

    // Status and sense
    localparam logic [7:0] STATUS_GOOD    = 8'h00;
    localparam logic [7:0] STATUS_CHECK   = 8'h02;
    localparam logic [3:0] SENSE_NONE     = 4'h0;
    localparam logic [3:0] SENSE_ILLEGAL  = 4'h5;
    localparam logic [7:0] ASC_NONE       = 8'h00;
    localparam logic [7:0] ASC_INV_FIELD  = 8'h24;

    // Initiator count for unit attentions
    localparam int          NUM_INIT  = 4;
    localparam int          INIT_W    = 2;

    // Echo buffer: 64 words of 32 bits in flip-flops
    localparam int          ECHO_DEPTH = 64;
    localparam int          ECHO_AW    = 6;

    // Host guard time for a saved update
    localparam int          SAVE_TIMEOUT_S = 30;
    localparam longint      CLK_HZ         = 64'd200_000_000;
    localparam longint      SAVE_TIMEOUT_CYC = SAVE_TIMEOUT_S * CLK_HZ;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_DATA  = 3'b011,
        ST_DONE  = 3'b010,
        ST_RESP  = 3'b110
    } dev_state_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b00,
        HS_CMD  = 2'b01,
        HS_DATA = 2'b11,
        HS_WAIT = 2'b10
    } host_state_t;

endpackage
